// ---- aoc_cfg_ram.sv ----
// Purpose: Configuration word store, one write/read port and one read port.
// Assumes: Single clock; both read ports return data one cycle after the address.
// Notes:   Contents are not reset; the owner sweeps defaults in after reset.
`timescale 1ns/1ns
module aoc_cfg_ram (
	input  wire  logic        ref_clk_i,
	input  wire  logic        a_we_i,
	input  wire  logic [4:0]  a_addr_i,
	input  wire  logic [15:0] a_wdata_i,
	output logic       [15:0] a_rdata_o,
	input  wire  logic [4:0]  b_addr_i,
	output logic       [15:0] b_rdata_o
);

	logic [15:0] mem_q [0:31];

	always_ff @(posedge ref_clk_i) begin
		if (a_we_i) begin
			mem_q[a_addr_i] <= a_wdata_i;
		end
		a_rdata_o <= mem_q[a_addr_i];
		b_rdata_o <= mem_q[b_addr_i];
	end

endmodule

// ---- aoc_pkg.sv ----
// Purpose: Shared constants and types for the analog output channel processing block.
// Assumes: 125 MHz reference clock, four output channels, byte-addressed Avalon-MM map.
// Notes:   Codes run 0 to 4000; the working range is -20 % to 115 % of span.
package aoc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ         = 125000;
	localparam int CONV_PERIOD_MS  = 100;
	localparam int CONV_PERIOD_CYC = CONV_PERIOD_MS * CLK_KHZ;
	localparam int PER_W           = 24;

	// ----------------------------------------------------------------
	// Code scaling
	// ----------------------------------------------------------------
	localparam int                 NUM_CH     = 4;
	localparam logic signed [16:0] CODE_MIN   = 17'sh00000;
	localparam logic signed [16:0] CODE_MAX   = 17'sh00FA0;
	localparam logic signed [16:0] OUT_MIN    = -17'sh00320;
	localparam logic signed [16:0] OUT_MAX    = 17'sh011F8;
	localparam logic        [15:0] SPAN_ONE   = 16'h1000;
	localparam int                 SPAN_SHIFT = 12;
	localparam int                 DAC_W      = 13;
	localparam int                 MEAS_W     = 12;

	// Loop break threshold in microamps, mapped onto the code scale.
	localparam int LOOP_ZERO_UA  = 4000;
	localparam int LOOP_SPAN_UA  = 16000;
	localparam int LOOP_BRK_UA   = 500;
	localparam int LOOP_BRK_CODE = -((LOOP_ZERO_UA - LOOP_BRK_UA) * 4000 / LOOP_SPAN_UA);

	// ----------------------------------------------------------------
	// Per-channel configuration fields
	// ----------------------------------------------------------------
	localparam logic [2:0] FLD_SET    = 3'h0;
	localparam logic [2:0] FLD_PRESET = 3'h1;
	localparam logic [2:0] FLD_POS    = 3'h2;
	localparam logic [2:0] FLD_NEG    = 3'h3;
	localparam logic [2:0] FLD_ZERO   = 3'h4;
	localparam logic [2:0] FLD_SPAN   = 3'h5;
	localparam logic [2:0] FLD_HI     = 3'h6;
	localparam logic [2:0] FLD_LO     = 3'h7;
	localparam int         NUM_FLD    = 8;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RAM_END = 8'h80;
	localparam logic [7:0] ADDR_CTRL    = 8'h80;
	localparam logic [7:0] ADDR_STATUS  = 8'h84;
	localparam logic [7:0] ADDR_MASK    = 8'h88;
	localparam logic [7:0] ADDR_BREAK   = 8'h8C;
	localparam logic [7:0] ADDR_ANS0    = 8'h90;
	localparam logic [7:0] ADDR_ANS3    = 8'h9C;
	localparam int         CTRL_MODE_LSB = 0;
	localparam int         CTRL_HSEL_LSB = 4;
	localparam int         CTRL_OFF_BIT  = 8;
	localparam int         CTRL_W        = 9;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		E_IDLE  = 8'h01,
		E_FETCH = 8'h02,
		E_LOAD  = 8'h04,
		E_HOLD  = 8'h08,
		E_RATE  = 8'h10,
		E_ZS    = 8'h20,
		E_LIM   = 8'h40,
		E_OUT   = 8'h80
	} aoc_eng_t;

	typedef enum logic [2:0] {
		B_IDLE = 3'h1,
		B_ACT  = 3'h2,
		B_DONE = 3'h4
	} aoc_bus_t;

endpackage

// ---- aoc_plant.sv ----
// Purpose: Converter and measuring loop on the far side of aoc_top.
// Assumes: Each channel holds its last loaded code; the ADC reads the selected one.
// Notes:   An open loop reads far below zero current, as a broken wire would.
`timescale 1ns/1ns
module aoc_plant (
	input  wire logic                              ref_clk_i,
	input  wire logic        [aoc_pkg::DAC_W-1:0]  dac_code_i,
	input  wire logic        [1:0]                 dac_ch_i,
	input  wire logic                              dac_load_i,
	input  wire logic        [1:0]                 meas_ch_i,
	input  wire logic        [3:0]                 brk_i,
	output logic signed      [aoc_pkg::MEAS_W-1:0] meas_o
);
	logic [aoc_pkg::DAC_W-1:0] lvl_q [4] = '{13'h0320, 13'h0320, 13'h0320, 13'h0320};
	always @(posedge ref_clk_i) begin
		if (dac_load_i) begin
			lvl_q[dac_ch_i] <= dac_code_i;
		end
	end
	always_comb begin
		if (brk_i[meas_ch_i]) begin
			meas_o = -12'sd600;
		end else if (lvl_q[meas_ch_i] > 13'h131E) begin
			meas_o = 12'sd2047;
		end else begin
			meas_o = 12'((signed'({1'b0, lvl_q[meas_ch_i]}) - 14'sd800) >>> 1);
		end
	end
endmodule

// ---- aoc_top.sv ----
// Purpose: Four-channel analog output processing with converter drive and answer readback.
// Assumes: Avalon-MM slave with waitrequest; external converter and measuring ADC.
// Notes:   One pass over all channels per conversion period.
//
// Overview of operation
// - Set values are codes 0 to 4000, fixed scaling.
// - Hold, rate limit, zero/span, clamp in order.
// - Converter resolves span into 4000 code steps.
// - All four channels updated every 100 ms.
// - Answer code reports measured output, half resolution.
// - Current mode flags loop break at 0.5 mA.
// - Separate rise and fall step limits per period.
// - Output clamped between low and high limits.
// - Four channels, each current or voltage mode.
// - Processor fault or outputs-off selects hold value.
`timescale 1ns/1ns
module aoc_top #(
	parameter int CONV_CYC = aoc_pkg::CONV_PERIOD_CYC
) (
	input  wire  logic                             ref_clk_i,
	input  wire  logic                             rst_i,
	input  wire  logic        [7:0]                avs_address_i,
	input  wire  logic                             avs_read_i,
	input  wire  logic                             avs_write_i,
	input  wire  logic        [31:0]               avs_writedata_i,
	output logic              [31:0]               avs_readdata_o,
	output logic                                   avs_waitrequest_o,
	input  wire  logic                             cpu_fatal_i,
	input  wire  logic                             cpu_err_i,
	input  wire  logic signed [aoc_pkg::MEAS_W-1:0] meas_i,
	output logic              [1:0]                meas_ch_o,
	output logic              [aoc_pkg::DAC_W-1:0] dac_code_o,
	output logic              [1:0]                dac_ch_o,
	output logic                                   dac_load_o,
	output logic              [3:0]                out_mode_o,
	output logic                                   irq_o
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic signed [16:0] clip(input logic signed [33:0] x,
		input logic signed [16:0] lo, input logic signed [16:0] hi);
		logic signed [16:0] r;
		r = 17'(x);
		if (x > 34'(hi)) begin
			r = hi;
		end else if (x < 34'(lo)) begin
			r = lo;
		end
		return r;
	endfunction

	function automatic logic [15:0] cfg_default(input logic [2:0] fld);
		logic [15:0] r;
		r = 16'h0000;
		if (fld == aoc_pkg::FLD_SPAN) begin
			r = aoc_pkg::SPAN_ONE;
		end else if (fld == aoc_pkg::FLD_HI) begin
			r = aoc_pkg::CODE_MAX[15:0];
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	aoc_pkg::aoc_bus_t          bus_q;
	aoc_pkg::aoc_eng_t          eng_q;
	logic [5:0]                 init_q;
	logic                       init_busy;
	logic                       fatal_s1_q, fatal_s2_q, err_s1_q, err_s2_q;
	logic signed [aoc_pkg::MEAS_W-1:0] meas_s1_q, meas_s2_q;
	logic [aoc_pkg::CTRL_W-1:0] ctrl_q;
	logic [3:0]                 status_q, status_d, mask_q, brk_q, brk_set;
	logic [15:0]                ans_q [0:3];
	logic signed [16:0]         prev_q [0:3];
	logic [15:0]                cfg_q [0:aoc_pkg::NUM_FLD-1];
	logic signed [16:0]         work_q;
	logic [1:0]                 ch_q;
	logic [2:0]                 fld_q;
	logic [aoc_pkg::PER_W-1:0]  per_q;
	logic                       tick_q;
	logic                       ram_we, ram_hit, bus_rd, bus_wr, hold_on;
	logic [4:0]                 ram_a_addr;
	logic [15:0]                ram_wdata, ram_a_rdata, ram_b_rdata, set_wr;
	logic signed [17:0]         delta;
	logic signed [33:0]         zs_prod, zs_sum, meas_x2;
	logic signed [16:0]         pos_lim, neg_lim;

	// ----------------------------------------------------------------
	// Input synchronisers and default sweep
	// ----------------------------------------------------------------
	// The measurement bus is sampled long after its channel is selected, so
	// only settled words pass the two stages.
	always_ff @(posedge ref_clk_i) begin
		fatal_s1_q <= cpu_fatal_i;
		fatal_s2_q <= fatal_s1_q;
		err_s1_q   <= cpu_err_i;
		err_s2_q   <= err_s1_q;
		meas_s1_q  <= meas_i;
		meas_s2_q  <= meas_s1_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			init_q <= 6'h00;
		end else if (init_busy) begin
			init_q <= init_q + 6'h01;
		end
	end
	assign init_busy = !init_q[5];

	// ----------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bus_q <= aoc_pkg::B_IDLE;
		end else begin
			case (bus_q)
				aoc_pkg::B_IDLE: begin
					if ((avs_read_i || avs_write_i) && !init_busy) begin
						bus_q <= aoc_pkg::B_ACT;
					end
				end
				aoc_pkg::B_ACT:  bus_q <= aoc_pkg::B_DONE;
				default:         bus_q <= aoc_pkg::B_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= (bus_q != aoc_pkg::B_ACT);
		end
	end

	assign bus_rd  = (bus_q == aoc_pkg::B_ACT) && avs_read_i;
	// Writes land on the edge at which the master sees waitrequest low, not before.
	assign bus_wr  = (bus_q == aoc_pkg::B_DONE) && avs_write_i;
	assign ram_hit = avs_address_i < aoc_pkg::ADDR_RAM_END;

	// Set values above full scale are held at full scale so the code stays in range.
	assign set_wr = (avs_writedata_i[15:0] > aoc_pkg::CODE_MAX[15:0]) ?
		aoc_pkg::CODE_MAX[15:0] : avs_writedata_i[15:0];

	always_comb begin
		ram_a_addr = avs_address_i[6:2];
		ram_wdata  = avs_writedata_i[15:0];
		ram_we     = bus_wr && ram_hit;
		if (init_busy) begin
			ram_a_addr = init_q[4:0];
			ram_wdata  = cfg_default(init_q[2:0]);
			ram_we     = 1'b1;
		end else if (avs_address_i[4:2] == aoc_pkg::FLD_SET) begin
			ram_wdata = set_wr;
		end
	end

	aoc_cfg_ram i_aoc_cfg_ram (
		.ref_clk_i (ref_clk_i),
		.a_we_i    (ram_we),
		.a_addr_i  (ram_a_addr),
		.a_wdata_i (ram_wdata),
		.a_rdata_o (ram_a_rdata),
		.b_addr_i  ({ch_q, fld_q}),
		.b_rdata_o (ram_b_rdata)
	);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl_q <= '0;
			mask_q <= 4'h0;
		end else if (bus_wr && avs_address_i == aoc_pkg::ADDR_CTRL) begin
			ctrl_q <= avs_writedata_i[aoc_pkg::CTRL_W-1:0];
		end else if (bus_wr && avs_address_i == aoc_pkg::ADDR_MASK) begin
			mask_q <= avs_writedata_i[3:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (bus_rd) begin
			if (ram_hit) begin
				avs_readdata_o <= {16'h0000, ram_a_rdata};
			end else if (avs_address_i == aoc_pkg::ADDR_CTRL) begin
				avs_readdata_o <= 32'(ctrl_q);
			end else if (avs_address_i == aoc_pkg::ADDR_STATUS) begin
				avs_readdata_o <= 32'(status_q);
			end else if (avs_address_i == aoc_pkg::ADDR_MASK) begin
				avs_readdata_o <= 32'(mask_q);
			end else if (avs_address_i == aoc_pkg::ADDR_BREAK) begin
				avs_readdata_o <= 32'(brk_q);
			end else if (avs_address_i >= aoc_pkg::ADDR_ANS0 &&
				avs_address_i <= aoc_pkg::ADDR_ANS3) begin
				avs_readdata_o <= {16'h0000, ans_q[avs_address_i[3:2]]};
			end else begin
				avs_readdata_o <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	// A break found in the same cycle as the clearing read stays set.
	always_comb begin
		status_d = status_q;
		if (bus_rd && avs_address_i == aoc_pkg::ADDR_STATUS) begin
			status_d = 4'h0;
		end
		status_d = status_d | brk_set;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			status_q <= 4'h0;
			irq_o    <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_o    <= |(status_q & mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Conversion period timer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			per_q  <= '0;
			tick_q <= 1'b0;
		end else if (per_q == aoc_pkg::PER_W'(CONV_CYC - 1)) begin
			per_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			per_q  <= per_q + aoc_pkg::PER_W'(1);
			tick_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Channel processing datapath
	// ----------------------------------------------------------------
	assign hold_on = fatal_s2_q || err_s2_q || ctrl_q[aoc_pkg::CTRL_OFF_BIT];
	assign delta   = 18'(work_q) - 18'(prev_q[ch_q]);
	assign pos_lim = $signed({1'b0, cfg_q[aoc_pkg::FLD_POS]});
	assign neg_lim = $signed({1'b0, cfg_q[aoc_pkg::FLD_NEG]});
	assign zs_prod = work_q * $signed({1'b0, cfg_q[aoc_pkg::FLD_SPAN]});
	assign zs_sum  = (zs_prod >>> aoc_pkg::SPAN_SHIFT) +
		34'(signed'(cfg_q[aoc_pkg::FLD_ZERO]));
	assign meas_x2 = 34'(meas_s2_q) <<< 1;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			eng_q     <= aoc_pkg::E_IDLE;
			ch_q      <= 2'h0;
			fld_q     <= 3'h0;
			work_q    <= '0;
			meas_ch_o <= 2'h0;
		end else begin
			case (eng_q)
				aoc_pkg::E_IDLE: begin
					if (tick_q && !init_busy) begin
						ch_q  <= 2'h0;
						fld_q <= 3'h0;
						eng_q <= aoc_pkg::E_FETCH;
					end
				end
				aoc_pkg::E_FETCH: eng_q <= aoc_pkg::E_LOAD;
				aoc_pkg::E_LOAD: begin
					cfg_q[fld_q] <= ram_b_rdata;
					if (fld_q == 3'h0) begin
						meas_ch_o <= ch_q;
					end
					if (fld_q == 3'(aoc_pkg::NUM_FLD - 1)) begin
						eng_q <= aoc_pkg::E_HOLD;
					end else begin
						fld_q <= fld_q + 3'h1;
						eng_q <= aoc_pkg::E_FETCH;
					end
				end
				aoc_pkg::E_HOLD: begin
					if (!hold_on) begin
						work_q <= $signed({1'b0, cfg_q[aoc_pkg::FLD_SET]});
					end else if (ctrl_q[aoc_pkg::CTRL_HSEL_LSB + int'(ch_q)]) begin
						work_q <= clip(34'($signed({1'b0, cfg_q[aoc_pkg::FLD_PRESET]})),
							aoc_pkg::CODE_MIN, aoc_pkg::CODE_MAX);
					end else begin
						work_q <= prev_q[ch_q];
					end
					eng_q <= aoc_pkg::E_RATE;
				end
				aoc_pkg::E_RATE: begin
					// A zero step limit leaves that direction unlimited.
					if (pos_lim != 17'sh00000 && delta > 18'(pos_lim)) begin
						work_q <= prev_q[ch_q] + pos_lim;
					end else if (neg_lim != 17'sh00000 && -delta > 18'(neg_lim)) begin
						work_q <= prev_q[ch_q] - neg_lim;
					end
					eng_q <= aoc_pkg::E_ZS;
				end
				aoc_pkg::E_ZS: begin
					work_q <= clip(zs_sum, aoc_pkg::OUT_MIN, aoc_pkg::OUT_MAX);
					eng_q  <= aoc_pkg::E_LIM;
				end
				aoc_pkg::E_LIM: begin
					work_q <= clip(34'(clip(34'(work_q),
						17'(signed'(cfg_q[aoc_pkg::FLD_LO])),
						17'(signed'(cfg_q[aoc_pkg::FLD_HI])))),
						aoc_pkg::OUT_MIN, aoc_pkg::OUT_MAX);
					eng_q  <= aoc_pkg::E_OUT;
				end
				aoc_pkg::E_OUT: begin
					fld_q <= 3'h0;
					if (ch_q == 2'(aoc_pkg::NUM_CH - 1)) begin
						eng_q <= aoc_pkg::E_IDLE;
					end else begin
						ch_q  <= ch_q + 2'h1;
						eng_q <= aoc_pkg::E_FETCH;
					end
				end
				default: eng_q <= aoc_pkg::E_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Converter drive, answer readback and loop break
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dac_code_o <= '0;
			dac_ch_o   <= 2'h0;
			dac_load_o <= 1'b0;
			brk_q      <= 4'h0;
			for (int i = 0; i < aoc_pkg::NUM_CH; i++) begin
				prev_q[i] <= '0;
				ans_q[i]  <= 16'h0000;
			end
		end else begin
			dac_load_o <= 1'b0;
			if (eng_q == aoc_pkg::E_OUT) begin
				prev_q[ch_q] <= work_q;
				// One converter count per code count, offset for the -20 % floor.
				dac_code_o <= aoc_pkg::DAC_W'(work_q - aoc_pkg::OUT_MIN);
				dac_ch_o   <= ch_q;
				dac_load_o <= 1'b1;
				ans_q[ch_q] <= 16'(clip(meas_x2, aoc_pkg::CODE_MIN, aoc_pkg::CODE_MAX));
				brk_q[ch_q] <= ctrl_q[aoc_pkg::CTRL_MODE_LSB + int'(ch_q)] &&
					(meas_x2 <= 34'(aoc_pkg::LOOP_BRK_CODE));
			end
		end
	end

	always_comb begin
		brk_set = 4'h0;
		if (eng_q == aoc_pkg::E_OUT && ctrl_q[aoc_pkg::CTRL_MODE_LSB + int'(ch_q)] &&
			meas_x2 <= 34'(aoc_pkg::LOOP_BRK_CODE)) begin
			brk_set[ch_q] = 1'b1;
		end
	end

	assign out_mode_o = ctrl_q[aoc_pkg::CTRL_MODE_LSB +: 4];

endmodule

// ---- aoc_top_assertions.sv ----
// Purpose: Bus, converter and interrupt timing checks for aoc_top.
// Assumes: Bound to aoc_top; the pass spacing follows the CONV_CYC parameter.
// Notes:   Helper counters stand in for long waits that repetition cannot express.
`timescale 1ns/1ns
module aoc_top_assertions #(
	parameter int CONV_CYC = 200
) (
	input wire logic                      ref_clk_i,
	input wire logic                      rst_i,
	input wire logic [7:0]                avs_address_i,
	input wire logic                      avs_read_i,
	input wire logic                      avs_write_i,
	input wire logic                      avs_waitrequest_o,
	input wire logic [aoc_pkg::DAC_W-1:0] dac_code_o,
	input wire logic [1:0]                dac_ch_o,
	input wire logic                      dac_load_o,
	input wire logic                      irq_o
);
	logic [5:0]  up_q;
	logic [31:0] per_q;
	logic        seen_q;
	logic [1:0]  last_ch_q;
	logic [2:0]  evt_q;
	logic        st_acc;
	assign st_acc = !avs_waitrequest_o && (avs_address_i == aoc_pkg::ADDR_STATUS
		|| avs_address_i == aoc_pkg::ADDR_MASK);
	// The sweep after reset delays the first answer, so latency is judged after it.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			up_q <= 6'h00;
		end else if (up_q != 6'h28) begin
			up_q <= up_q + 6'h01;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || (dac_load_o && dac_ch_o == 2'h0)) begin
			per_q <= 32'h00000000;
		end else begin
			per_q <= per_q + 32'h00000001;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			seen_q <= 1'b0;
			last_ch_q <= 2'h0;
		end else if (dac_load_o) begin
			seen_q <= seen_q | (dac_ch_o == 2'h0);
			last_ch_q <= dac_ch_o;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			evt_q <= 3'h0;
		end else if (dac_load_o || (avs_write_i && !avs_waitrequest_o)) begin
			evt_q <= 3'h6;
		end else if (evt_q != 3'h0) begin
			evt_q <= evt_q - 3'h1;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_wait_two;
		avs_waitrequest_o [*2];
	endsequence
	sequence s_answer;
		s_wait_two ##1 !avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	chk_bus_latency: assert property ((up_q == 6'h28) && $rose(avs_read_i || avs_write_i)
		|-> s_answer) else $error("Bus answer latency wrong.");
	chk_sweep_wait: assert property (up_q < 6'h20 |-> avs_waitrequest_o)
		else $error("Bus answered during the sweep.");
	chk_answer_cause: assert property (!avs_waitrequest_o |-> avs_read_i || avs_write_i)
		else $error("Bus answered without a request.");
	chk_load_pulse: assert property (dac_load_o |=> !dac_load_o)
		else $error("Converter load longer than one cycle.");
	chk_channel_order: assert property (dac_load_o && dac_ch_o != 2'h0
		|-> dac_ch_o == last_ch_q + 2'h1 && $past(dac_load_o, 21))
		else $error("Converter channel order or spacing wrong.");
	chk_pass_period: assert property (dac_load_o && dac_ch_o == 2'h0 && seen_q
		|-> per_q == CONV_CYC - 1) else $error("Conversion period wrong.");
	chk_code_range: assert property (dac_load_o |-> dac_code_o <= 13'h1518)
		else $error("Converter code beyond the clamp range.");
	chk_irq_fall: assert property ($fell(irq_o) |-> $past(st_acc) || $past(st_acc, 2))
		else $error("Interrupt fell without a status read or mask write.");
	chk_irq_rise: assert property ($rose(irq_o) |-> evt_q != 3'h0)
		else $error("Interrupt rose without a load or a write.");
endmodule
bind aoc_top aoc_top_assertions #(.CONV_CYC(CONV_CYC)) i_aoc_top_assertions (.ref_clk_i,
	.rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .dac_code_o,
	.dac_ch_o, .dac_load_o, .irq_o);

// ---- aoc_top_test.sv ----
// Purpose: Self-checking bench for aoc_top with the converter plant.
// Assumes: CONV_CYC cut to 200 cycles so a pass leaves a gap for writes.
// Notes:   Writes sit in the gap after channel 3 loads, so a pass never sees half a change.
`timescale 1ns/1ns
module aoc_top_test;
	logic                              ref_clk_i = 1'b0;
	logic                              rst_i = 1'b1;
	logic        [7:0]                 avs_address_i = 8'h00;
	logic                              avs_read_i = 1'b0;
	logic                              avs_write_i = 1'b0;
	logic        [31:0]                avs_writedata_i = 32'h00000000;
	logic        [31:0]                avs_readdata_o;
	logic                              avs_waitrequest_o;
	logic                              cpu_fatal_i = 1'b0;
	logic                              cpu_err_i = 1'b0;
	logic signed [aoc_pkg::MEAS_W-1:0] meas_i;
	logic        [1:0]                 meas_ch_o;
	logic        [aoc_pkg::DAC_W-1:0]  dac_code_o;
	logic        [1:0]                 dac_ch_o;
	logic                              dac_load_o;
	logic        [3:0]                 out_mode_o;
	logic                              irq_o;
	logic        [3:0]                 brk = 4'h0;
	logic        [14:0]                exp_q [$];
	logic        [31:0]                q;
	int                                fails = 0;
	int                                n_tests = 0;
	int                                seed = 92;
	int                                v1;
	int                                v2;
	always #4 ref_clk_i = ~ref_clk_i;
	aoc_top #(.CONV_CYC(200)) i_aoc_top (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .cpu_fatal_i,
		.cpu_err_i, .meas_i, .meas_ch_o, .dac_code_o, .dac_ch_o, .dac_load_o, .out_mode_o,
		.irq_o);
	aoc_plant i_aoc_plant (.ref_clk_i(ref_clk_i), .dac_code_i(dac_code_o), .dac_ch_i(dac_ch_o),
		.dac_load_i(dac_load_o), .meas_ch_i(meas_ch_o), .brk_i(brk), .meas_o(meas_i));
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_tests++;
		if (seen !== ex) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", nm, ex, seen);
		end
	endtask
	// The request stands until the edge that samples waitrequest low; data are taken there.
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 80);
		if (avs_waitrequest_o !== 1'b0) begin
			fails++;
			tally_and_finish();
		end else begin
			q = avs_readdata_o;
			avs_write_i <= 1'b0;
			avs_read_i <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
		acc(1'b0, a, 32'h00000000);
		check(nm, q, ex);
	endtask
	task automatic sync;
		int n;
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (!(dac_load_o === 1'b1 && dac_ch_o === 2'h3) && n < 400);
		if (n == 400) begin
			fails++;
			tally_and_finish();
		end
	endtask
	task automatic note(input int e[4]);
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back({2'(i), 13'(e[i] + 800)});
		end
	endtask
	always @(negedge ref_clk_i) begin
		if (dac_load_o === 1'b1 && exp_q.size() > 0) begin
			check("dac load", {dac_ch_o, dac_code_o}, exp_q.pop_front());
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		v1 = 100 + 2 * ($unsigned($random(seed)) % 1900);
		v2 = 2 * ($unsigned($random(seed)) % 2000);
		rd(aoc_pkg::ADDR_CTRL, 32'h00000000, "ctrl");
		rd(aoc_pkg::ADDR_STATUS, 32'h00000000, "status");
		rd(aoc_pkg::ADDR_MASK, 32'h00000000, "mask");
		rd(8'h34, 32'h00001000, "span");
		rd(8'h58, 32'h00000FA0, "high");
		wr(8'hA0, 32'h00001234);
		rd(8'hA0, 32'h00000000, "unmapped");
		$display("Test reset values done");
		sync();
		wr(8'h00, 32'h000007D0);
		wr(8'h20, 32'(v1));
		wr(8'h40, 32'(v2));
		wr(8'h60, 32'h00001388);
		rd(8'h60, 32'h00000FA0, "set clamp");
		note('{2000, v1, v2, 4000});
		sync();
		sync();
		rd(8'h90, 32'h000007D0, "answer0");
		rd(8'h94, 32'(v1), "answer1");
		rd(8'h98, 32'(v2), "answer2");
		rd(8'h9C, 32'h00000FA0, "answer3");
		$display("Test set and answer done");
		sync();
		wr(8'h08, 32'h00000064);
		wr(8'h00, 32'h00000FA0);
		wr(8'h2C, 32'h00000032);
		wr(8'h20, 32'h00000000);
		wr(8'h54, 32'h00000800);
		wr(8'h50, 32'h00000064);
		wr(8'h74, 32'h00002000);
		wr(8'h78, 32'h00000BB8);
		wr(8'h60, 32'h000007D0);
		note('{2100, v1 - 50, v2 / 2 + 100, 3000});
		sync();
		$display("Test rate span limit done");
		sync();
		wr(8'h08, 32'h00000000);
		wr(8'h2C, 32'h00000000);
		wr(8'h54, 32'h00001000);
		wr(8'h50, 32'h00000000);
		wr(8'h74, 32'h00001000);
		wr(8'h04, 32'h000004D2);
		// The first hold takes the preset, the later ones keep what it left.
		for (int k = 0; k < 3; k++) begin
			sync();
			wr(aoc_pkg::ADDR_CTRL, (k == 0) ? 32'h00000110 : 32'h00000000);
			cpu_fatal_i <= (k == 1);
			cpu_err_i <= (k == 2);
			wr(8'h20, 32'h00000BB8);
			note('{1234, 0, v2, 2000});
		end
		sync();
		wr(aoc_pkg::ADDR_CTRL, 32'h00000000);
		cpu_fatal_i <= 1'b0;
		cpu_err_i <= 1'b0;
		wr(8'h7C, 32'h000009C4);
		note('{4000, 3000, v2, 2500});
		sync();
		$display("Test output hold done");
		brk <= 4'h6;
		wr(aoc_pkg::ADDR_CTRL, 32'h00000004);
		wr(aoc_pkg::ADDR_MASK, 32'h00000004);
		check("mode", out_mode_o, 32'h00000004);
		sync();
		sync();
		check("irq set", irq_o, 32'h00000001);
		rd(aoc_pkg::ADDR_BREAK, 32'h00000004, "break live");
		wr(aoc_pkg::ADDR_MASK, 32'h00000000);
		repeat (3) @(negedge ref_clk_i);
		check("irq masked", irq_o, 32'h00000000);
		rd(aoc_pkg::ADDR_STATUS, 32'h00000004, "status set");
		brk <= 4'h0;
		wr(aoc_pkg::ADDR_MASK, 32'h00000004);
		sync();
		rd(aoc_pkg::ADDR_STATUS, 32'h00000000, "status clear");
		check("irq clear", irq_o, 32'h00000000);
		$display("Test loop break done");
		repeat (5) @(negedge ref_clk_i);
		check("notes left", exp_q.size(), 32'h00000000);
		tally_and_finish();
	end
endmodule
